// ---- shared/mbr_pkg.sv ----
`default_nettype none
package mbr_pkg;
  localparam logic [7:0]  FC_DISCRETE   = 8'h02;
  localparam logic [7:0]  FC_HOLDING    = 8'h03;
  localparam logic [7:0]  FC_INPUT      = 8'h04;
  localparam logic [7:0]  FC_ERROR_BIT  = 8'h80;
  localparam logic [7:0]  EXC_FUNCTION  = 8'h01;
  localparam logic [7:0]  EXC_ADDRESS   = 8'h02;
  localparam logic [15:0] CRC_INIT      = 16'hffff;
  localparam logic [15:0] CRC_POLY      = 16'ha001;
  localparam int          REQ_LEN       = 8;
  localparam int          HEAD_LEN      = 3;
  localparam logic [15:0] MAX_BITS      = 16'h07d0;
  localparam logic [15:0] MAX_REGS      = 16'h007d;
  localparam logic [7:0]  DEFAULT_ID    = 8'h01;

  function automatic logic [15:0] mbr_crc_byte(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : mbr_crc_byte
endpackage : mbr_pkg
`default_nettype wire

// ---- logic/mbr_crc.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbr_crc
  import mbr_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        clear,
  input  wire logic        enable,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);
  // Running CRC over each enabled character, cleared at telegram start
  always_ff @(posedge mclk)
  begin
    if (clear)
    begin
      crc <= CRC_INIT;
    end
    else if (enable)
    begin
      crc <= mbr_crc_byte(crc, data); // R14
    end
  end
endmodule : mbr_crc
`default_nettype wire

// ---- logic/mbr_read_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// R01: Function 02 returns consecutive discrete input states from start for count.
// R02: Master sends eight characters: id, function, start, count, CRC low/high.
// R03: Answer holds id, function, byte count, data bytes, then CRC.
// R04: Discrete states pack eight per byte, one bit per point.
// R05: Discrete byte count is point count divided by eight rounded up.
// R06: Leftover states fill lowest bits of last byte, upper bits zero.
// R07: Bit 0 of byte n holds point start plus eight times n.
// R08: Function 03 returns consecutive holding registers from start for count.
// R09: Function 04 returns consecutive input registers from start for count.
// R10: Each register gives two bytes; byte count is twice register count.
// R11: Master reads a float as two input registers, four data bytes.
// R12: Response echoes own slave id first and request function second.
// R13: Register values and request fields are high byte first.
// R14: CRC-16 over all preceding characters, appended low byte first.
// R15: Request errors answer function with top bit set plus error code.
// R16: Invalid register range gives error code 2.
// R17: CRC or parity fault is logged and no response is sent.
module mbr_read_slave
  import mbr_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [7:0]        slaveId,
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxData,
  input  wire logic              rxParityErr,
  input  wire logic              rxFrameEnd,
  output logic                   txValid,
  output logic      [7:0]        txData,
  input  wire logic              txReady,
  output logic                   dataReq,
  output logic      [1:0]        dataSpace,
  output logic      [15:0]       dataAddr,
  input  wire logic              dataAck,
  input  wire logic              dataOk,
  input  wire logic [15:0]       dataWord,
  input  wire logic              dataBit,
  output logic      [15:0]       crcFaults
);
  import mbr_pkg::*;

  typedef enum logic [5:0] {
    ST_RECV  = 6'b000001,
    ST_CHECK = 6'b000010,
    ST_FETCH = 6'b000100,
    ST_SEND  = 6'b001000,
    ST_WAIT  = 6'b010000,
    ST_FLUSH = 6'b100000
  } mbr_state_type;

  typedef struct packed {
    mbr_state_type state;
    logic [3:0]    rxCount;
    logic [7:0]    reqId;
    logic [7:0]    reqFunc;
    logic [15:0]   reqStart;
    logic [15:0]   reqCount;
    logic [15:0]   rxCrcWord;
    logic          parityBad;
    logic [15:0]   itemIdx;
    logic [7:0]    packByte;
    logic [2:0]    packBit;
    logic          lowHalf;
    logic [7:0]    lowByte;
    logic [3:0]    txPhase;
    logic [7:0]    byteCount;
    logic [7:0]    bytesSent;
    logic          errReply;
    logic [7:0]    errCode;
    logic          txValid;
    logic [7:0]    txData;
    logic          dataReq;
    logic [1:0]    dataSpace;
    logic [15:0]   dataAddr;
    logic [15:0]   crcFaults;
    logic          crcClear;
    logic          crcEnable;
    logic [7:0]    crcData;
  } mbr_regs_type;

  mbr_regs_type r;
  mbr_regs_type next_r;
  logic [15:0]  crc;

  mbr_crc u_crc (
    .mclk   (mclk),
    .clear  (r.crcClear),
    .enable (r.crcEnable),
    .data   (r.crcData),
    .crc    (crc)
  );

  // Phases of the answer
  localparam logic [3:0] PH_ID = 4'h0;
  localparam logic [3:0] PH_FN = 4'h1;
  localparam logic [3:0] PH_BC = 4'h2;
  localparam logic [3:0] PH_DT = 4'h3;
  localparam logic [3:0] PH_CL = 4'h4;
  localparam logic [3:0] PH_CH = 4'h5;

  function automatic logic isRegFunc(input logic [7:0] f);
    return (f == FC_HOLDING) || (f == FC_INPUT);
  endfunction : isRegFunc

  // Emit one character and fold it into the CRC; the CRC bytes themselves are excluded
  function automatic mbr_regs_type emit(input mbr_regs_type s, input logic [7:0] d, input logic toCrc);
    mbr_regs_type o;
    o = s;
    o.txValid   = 1'b1;
    o.txData    = d;
    o.crcEnable = toCrc;
    o.crcData   = d;
    return o;
  endfunction : emit

  always_comb
  begin
    logic [16:0] lastAddr;
    lastAddr = 17'h00000;
    next_r = r;
    next_r.crcClear  = 1'b0;
    next_r.crcEnable = 1'b0;
    if (txReady)
    begin
      next_r.txValid = 1'b0;
    end
    case (r.state)
      ST_RECV:
      begin
        if (rxValid)
        begin
          if (r.rxCount < 4'(REQ_LEN))
          begin
            next_r.rxCount = r.rxCount + 4'h1;
          end
          next_r.parityBad = r.parityBad | rxParityErr;
          next_r.crcEnable = (r.rxCount < 4'(REQ_LEN - 2));
          next_r.crcData   = rxData;
          case (r.rxCount) // R02
            4'h0: next_r.reqId = rxData;
            4'h1: next_r.reqFunc = rxData;
            4'h2: next_r.reqStart[15:8] = rxData; // R13
            4'h3: next_r.reqStart[7:0] = rxData;
            4'h4: next_r.reqCount[15:8] = rxData;
            4'h5: next_r.reqCount[7:0] = rxData;
            4'h6: next_r.rxCrcWord[7:0] = rxData;
            4'h7: next_r.rxCrcWord[15:8] = rxData;
            default: next_r.parityBad = 1'b1;
          endcase
        end
        if (rxFrameEnd)
        begin
          next_r.state = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        next_r.state = ST_RECV;
        next_r.crcClear = 1'b1;
        next_r.rxCount = 4'h0;
        next_r.parityBad = 1'b0;
        if (r.parityBad || r.rxCount != 4'(REQ_LEN) || crc != r.rxCrcWord)
        begin
          if (r.crcFaults != 16'hffff)
          begin
            next_r.crcFaults = r.crcFaults + 16'h0001; // R17
          end
        end
        else if (r.reqId == slaveId)
        begin
          // Broadcast id 0 matches only when slaveId is 0; otherwise it gets no answer
          lastAddr = {1'b0, r.reqStart} + {1'b0, r.reqCount};
          next_r.state = ST_SEND;
          next_r.txPhase = PH_ID;
          next_r.errReply = 1'b0;
          next_r.itemIdx = 16'h0000;
          next_r.bytesSent = 8'h00;
          next_r.packByte = 8'h00;
          next_r.packBit = 3'h0;
          next_r.lowHalf = 1'b0;
          if (r.reqFunc == FC_DISCRETE)
          begin
            next_r.byteCount = 8'((r.reqCount + 16'h0007) >> 3); // R05
          end
          else
          begin
            next_r.byteCount = 8'({r.reqCount, 1'b0}); // R10
          end
          if (!(r.reqFunc == FC_DISCRETE || isRegFunc(r.reqFunc)))
          begin
            next_r.errReply = 1'b1;
            next_r.errCode = EXC_FUNCTION;
          end
          else if (r.reqCount == 16'h0000 || lastAddr > 17'h10000
                   || r.reqCount > (r.reqFunc == FC_DISCRETE ? MAX_BITS : MAX_REGS))
          begin
            next_r.errReply = 1'b1;
            next_r.errCode = EXC_ADDRESS; // R16
          end
        end
      end
      ST_SEND:
      begin
        if (!r.txValid || txReady)
        begin
          case (r.txPhase)
            PH_ID:
            begin
              next_r = emit(next_r, slaveId, 1'b1); // R12
              next_r.txPhase = PH_FN;
            end
            PH_FN:
            begin
              next_r = emit(next_r, r.errReply ? (r.reqFunc | FC_ERROR_BIT) : r.reqFunc, 1'b1); // R15
              next_r.txPhase = PH_BC;
            end
            PH_BC:
            begin
              next_r = emit(next_r, r.errReply ? r.errCode : r.byteCount, 1'b1); // R03
              next_r.txPhase = r.errReply ? PH_CL : PH_DT;
            end
            PH_DT:
            begin
              if (r.bytesSent == r.byteCount)
              begin
                next_r.txPhase = PH_CL;
              end
              else if (isRegFunc(r.reqFunc) && r.lowHalf)
              begin
                next_r = emit(next_r, r.lowByte, 1'b1); // R13
                next_r.lowHalf = 1'b0;
                next_r.bytesSent = r.bytesSent + 8'h01;
              end
              else
              begin
                next_r.dataReq = 1'b1;
                next_r.dataSpace = r.reqFunc[1:0]; // R01 R08 R09
                next_r.dataAddr = r.reqStart + r.itemIdx;
                next_r.state = ST_FETCH;
              end
            end
            PH_CL:
            begin
              if (!r.crcEnable) // Last character's CRC update lands first
              begin
                next_r = emit(next_r, crc[7:0], 1'b0); // R14
                next_r.txPhase = PH_CH;
              end
            end
            PH_CH:
            begin
              next_r = emit(next_r, crc[15:8], 1'b0);
              next_r.state = ST_WAIT;
            end
            default: next_r.txPhase = PH_ID;
          endcase
        end
      end
      ST_FETCH:
      begin
        if (dataAck)
        begin
          next_r.dataReq = 1'b0;
          next_r.itemIdx = r.itemIdx + 16'h0001;
          if (!dataOk)
          begin
            // A hole in the map can only be found mid-answer; abandon without CRC
            next_r.state = ST_FLUSH;
          end
          else if (isRegFunc(r.reqFunc))
          begin
            next_r = emit(next_r, dataWord[15:8], 1'b1); // R10 R13
            next_r.lowByte = dataWord[7:0];
            next_r.lowHalf = 1'b1;
            next_r.bytesSent = r.bytesSent + 8'h01;
            next_r.state = ST_SEND;
          end
          else
          begin
            next_r.packByte = r.packByte | (8'(dataBit) << r.packBit); // R04 R07
            next_r.packBit = r.packBit + 3'h1;
            next_r.state = ST_SEND;
            if (r.packBit == 3'h7 || r.itemIdx + 16'h0001 == r.reqCount)
            begin
              next_r = emit(next_r, r.packByte | (8'(dataBit) << r.packBit), 1'b1); // R06
              next_r.packByte = 8'h00;
              next_r.packBit = 3'h0;
              next_r.bytesSent = r.bytesSent + 8'h01;
            end
          end
        end
      end
      ST_WAIT, ST_FLUSH:
      begin
        if (!r.txValid || txReady)
        begin
          next_r.state = ST_RECV;
          next_r.crcClear = 1'b1;
          next_r.rxCount = 4'h0;
          next_r.parityBad = 1'b0;
        end
      end
      default: next_r.state = ST_RECV;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      r <= '0;
      r.state <= ST_RECV;
      r.crcClear <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign txValid   = r.txValid;
  assign txData    = r.txData;
  assign dataReq   = r.dataReq;
  assign dataSpace = r.dataSpace;
  assign dataAddr  = r.dataAddr;
  assign crcFaults = r.crcFaults;

  sequence s_badCheck;
    r.state == ST_CHECK && (r.parityBad || crc != r.rxCrcWord);
  endsequence

  chk_fault_silent: assert property (@(posedge mclk) disable iff (rst) // R17
    s_badCheck |=> r.state == ST_RECV ##1 !r.txValid [*2])
    else $error("reply after faulty telegram");
  chk_fault_count: assert property (@(posedge mclk) disable iff (rst) // R17
    s_badCheck and r.crcFaults != 16'hffff |=> r.crcFaults == $past(r.crcFaults) + 16'h0001)
    else $error("fault not logged");
  chk_first_id: assert property (@(posedge mclk) disable iff (rst) // R12
    r.state == ST_SEND && r.txPhase == PH_ID && !r.txValid |=> r.txValid && r.txData == slaveId)
    else $error("first character not own id");
  chk_err_func: assert property (@(posedge mclk) disable iff (rst) // R15
    r.state == ST_SEND && r.txPhase == PH_FN && r.errReply && (!r.txValid || txReady) |=> r.txValid && r.txData[7])
    else $error("error reply lacks top bit");
  chk_disc_count: assert property (@(posedge mclk) disable iff (rst) // R05
    r.state == ST_CHECK && next_r.state == ST_SEND && r.reqFunc == FC_DISCRETE
    |=> r.byteCount == 8'((r.reqCount + 16'h0007) >> 3))
    else $error("discrete byte count wrong");
  chk_reg_count: assert property (@(posedge mclk) disable iff (rst) // R10
    r.state == ST_CHECK && next_r.state == ST_SEND && r.reqFunc == FC_HOLDING
    |=> r.byteCount == 8'(r.reqCount << 1))
    else $error("register byte count wrong");
  chk_range_code: assert property (@(posedge mclk) disable iff (rst) // R16
    r.state == ST_CHECK && next_r.state == ST_SEND && isRegFunc(r.reqFunc) && r.reqCount == 16'h0000
    |=> r.errReply && r.errCode == EXC_ADDRESS)
    else $error("bad range not code 2");
  chk_space_sel: assert property (@(posedge mclk) disable iff (rst) // R08
    $rose(r.dataReq) |-> r.dataSpace == r.reqFunc[1:0] && r.dataAddr == r.reqStart + r.itemIdx)
    else $error("fetch address wrong");
endmodule : mbr_read_slave
`default_nettype wire

// ---- verif/mbr_map_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mbr_map_model
(
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        slow,
  input  wire logic        dataReq,
  input  wire logic [1:0]  dataSpace,
  input  wire logic [15:0] dataAddr,
  output logic             dataAck,
  output logic             dataOk,
  output logic      [15:0] dataWord,
  output logic             dataBit
);
  logic [1:0]  waitCount;
  logic [15:0] word;
  logic        state;
  // Outside an answer the lines carry the inverse, so a stale read shows
  assign word     = {dataAddr[7:0] ^ 8'h5a, dataAddr[15:8]} ^ {14'h0000, dataSpace};
  assign state    = ^dataAddr ^ dataSpace[0];
  assign dataWord = dataAck ? word : ~word;
  assign dataBit  = dataAck ? state : ~state;
  assign dataOk   = dataAck;
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      waitCount <= 2'h0;
      dataAck   <= 1'b0;
    end
    else
    begin
      dataAck   <= dataReq && !dataAck && waitCount == 2'h0;
      waitCount <= (dataReq && !dataAck && waitCount != 2'h0) ? waitCount - 2'h1 : (slow ? 2'h3 : 2'h0);
    end
  end
endmodule : mbr_map_model
`default_nettype wire

// ---- verif/test_modbus_slave_read_functions.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_modbus_slave_read_functions;
  import mbr_pkg::*;
  logic        mclk, rst, rxValid, rxParityErr, rxFrameEnd, txValid, dataReq, dataAck, dataOk, dataBit, slow;
  logic        txReady = 1'b0;
  logic [7:0]  slaveId, rxData, txData;
  logic [1:0]  dataSpace;
  logic [15:0] dataAddr, dataWord, crcFaults, faults;
  logic [7:0]  txq[$];
  logic [7:0]  exp[$];
  int          fail_count, check_count, seed, n;
  mbr_read_slave dut (.mclk(mclk), .rst(rst), .slaveId(slaveId), .rxValid(rxValid), .rxData(rxData),
    .rxParityErr(rxParityErr), .rxFrameEnd(rxFrameEnd), .txValid(txValid), .txData(txData),
    .txReady(txReady), .dataReq(dataReq), .dataSpace(dataSpace), .dataAddr(dataAddr), .dataAck(dataAck),
    .dataOk(dataOk), .dataWord(dataWord), .dataBit(dataBit), .crcFaults(crcFaults));
  mbr_map_model model (.mclk(mclk), .rst(rst), .slow(slow), .dataReq(dataReq), .dataSpace(dataSpace),
    .dataAddr(dataAddr), .dataAck(dataAck), .dataOk(dataOk), .dataWord(dataWord), .dataBit(dataBit));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // Random stalls on the transmit side
  always @(negedge mclk) txReady <= $random(seed);
  always @(posedge mclk) if (txValid === 1'b1 && txReady === 1'b1) txq.push_back(txData);
  function automatic logic [15:0] crcOf(input logic [15:0] c, input logic [7:0] d);
    c = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    return c;
  endfunction : crcOf
  task automatic makeExp(input logic [7:0] fn, input logic [15:0] st, input logic [15:0] cnt);
    logic [15:0] c, w;
    logic [7:0]  v;
    v = 8'h00;
    exp.delete();
    exp.push_back(slaveId);
    if (fn < FC_DISCRETE || fn > FC_INPUT)
      exp = {exp, fn | FC_ERROR_BIT, EXC_FUNCTION};
    else if (cnt == 16'h0000 || cnt > (fn == FC_DISCRETE ? MAX_BITS : MAX_REGS) || 32'(st) + 32'(cnt) > 32'h10000)
      exp = {exp, fn | FC_ERROR_BIT, EXC_ADDRESS};
    else
    begin
      exp.push_back(fn);
      exp.push_back(fn == FC_DISCRETE ? 8'((cnt + 16'h0007) >> 3) : 8'(cnt << 1));
      for (int i = 0; i < int'(cnt); i++)
      begin
        w = {st[7:0] + 8'(i) ^ 8'h5a, 8'((st + 16'(i)) >> 8)};
        w[7:0] = 8'((st + 16'(i)) >> 8);
        w[15:8] = 8'(st + 16'(i)) ^ 8'h5a;
        if (fn != FC_DISCRETE)
          exp = {exp, w[15:8], w[7:0] ^ {6'h00, fn[1:0]}};
        else
        begin
          v[i % 8] = ^(st + 16'(i));
          if (i % 8 == 7 || i == int'(cnt) - 1) exp.push_back(v);
          if (i % 8 == 7) v = 8'h00;
        end
      end
    end
    c = CRC_INIT;
    foreach (exp[i]) c = crcOf(c, exp[i]);
    exp = {exp, c[7:0], c[15:8]};
  endtask : makeExp
  task automatic run(input logic [7:0] id, fn, input logic [15:0] st, cnt, input logic [1:0] fault);
    logic [7:0]  b[8];
    logic [15:0] c;
    int          t;
    b = '{id, fn, st[15:8], st[7:0], cnt[15:8], cnt[7:0], 8'h00, 8'h00};
    c = CRC_INIT;
    for (int i = 0; i < 6; i++) c = crcOf(c, b[i]);
    b[6] = c[7:0] ^ {7'h00, fault[0]};
    b[7] = c[15:8];
    txq.delete();
    for (int i = 0; i < 9; i++)
    begin
      @(negedge mclk);
      rxValid = i < 8;
      rxData = b[i % 8];
      rxParityErr = fault[1] && i == 3;
      rxFrameEnd = i == 8;
      @(negedge mclk);
      rxValid = 1'b0;
      rxFrameEnd = 1'b0;
    end
    exp.delete();
    if (fault != 2'b00) faults = faults + 16'h0001;
    else if (id == slaveId) makeExp(fn, st, cnt);
    t = 0;
    while (txq.size() < exp.size() && t < 20000)
    begin
      @(negedge mclk);
      t++;
    end
    if (t == 20000)
    begin
      $display("MISMATCH at %0t: no complete response", $time);
      fail_count++;
      results();
    end
    repeat (40) @(negedge mclk);
    compareWord(16'(txq.size()), 16'(exp.size()));
    foreach (exp[i]) if (i < txq.size()) compareByte(txq[i], exp[i]);
    compareWord(crcFaults, faults);
    $display("case fn %h count %0d done", fn, cnt);
  endtask : run
  task compareByte(input logic [7:0] got, input logic [7:0] want);
    check_count++;
    if (got !== want)
    begin
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, want);
      fail_count++;
    end
  endtask : compareByte
  task compareWord(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want)
    begin
      $display("MISMATCH at %0t: value %h expected %h", $time, got, want);
      fail_count++;
    end
  endtask : compareWord
  task results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results
  initial
  begin
    seed = 32'h89a8;
    {rxValid, rxParityErr, rxFrameEnd, slow, rxData, faults} = '0;
    {fail_count, check_count} = '0;
    rst = 1'b1;
    slaveId = 8'h01;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    run(8'h01, FC_DISCRETE, 16'h03e8, 16'h000c, 2'b00);
    run(8'h01, FC_DISCRETE, 16'h0010, 16'h0013, 2'b00);
    run(8'h01, FC_DISCRETE, 16'h0100, MAX_BITS, 2'b00);
    run(8'h01, FC_DISCRETE, 16'h0100, MAX_BITS + 16'h0001, 2'b00);
    run(8'h01, FC_HOLDING, 16'h03fe, 16'h0003, 2'b00);
    run(8'h01, FC_HOLDING, 16'h0000, MAX_REGS, 2'b00);
    run(8'h01, FC_HOLDING, 16'h0000, MAX_REGS + 16'h0001, 2'b00);
    run(8'h01, FC_INPUT, 16'h0bb8, 16'h0002, 2'b00);
    run(8'h01, FC_INPUT, 16'hfffe, 16'h0003, 2'b00);
    run(8'h01, FC_INPUT, 16'h0005, 16'h0000, 2'b00);
    run(8'h01, 8'h05, 16'h0000, 16'h0001, 2'b00);
    run(8'h07, FC_HOLDING, 16'h0000, 16'h0001, 2'b00);
    run(8'h00, FC_HOLDING, 16'h0000, 16'h0001, 2'b00);
    run(8'h01, FC_HOLDING, 16'h0001, 16'h0001, 2'b01);
    run(8'h01, FC_INPUT, 16'h0001, 16'h0002, 2'b10);
    slaveId = 8'h3c;
    for (n = 0; n < 12; n++)
    begin
      slow = $random(seed);
      run(slaveId, 8'h02 + 8'($unsigned($random(seed)) % 3), 16'($random(seed)) & 16'h7fff,
          16'h0001 + 16'($unsigned($random(seed)) % 40), 2'b00);
    end
    results();
  end
endmodule : test_modbus_slave_read_functions
`default_nettype wire
